// >>> test/ctrl_model.sv
// Behavioural memory controller that drives the module's pins
module ctrl_model
  import ddr_module_pkg::*;
(
  input wire logic clk,
  output cmd_pins_t pins,
  output logic cke,
  output logic [1:0] pair,
  output logic [1:0] pairB,
  output logic [LANES-1:0] masks,
  output logic [LANES-1:0] strobes,
  output logic [LANES-1:0] strobeOe,
  output logic [DATA_W-1:0] data,
  output logic dataDrv
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle pins: clock pair parked low, no-op code, nothing driven
  initial begin
    pins = {CMD_NOP, 2'h0, 13'h0000};
    cke = 1'b1;
    pair = PAIR_LOW;
    pairB = PAIR_LOW;
    masks = 8'h00;
    strobes = 8'h00;
    strobeOe = 8'h00;
    data = 64'h0000_0000_0000_0000;
    dataDrv = 1'b0;
  end
  // Whole cycles, then step just past the edge so pins never race it
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Clock enable is only moved between accesses, never inside one
  task automatic setCke(input logic v);
    cke = v;
  endtask
  // Rising crossing carrying one command; pins return to no-op after
  task automatic rise(input logic [3:0] code, input logic [BA_W-1:0] b,
                      input logic [ADDR_W-1:0] a);
    pins = {code, b, a};
    pair = PAIR_HIGH;
    pairB = PAIR_HIGH;
    waitClk(6);
    pins = {CMD_NOP, b, a};
  endtask
  // Falling crossing; the pair level lasts long enough to be synced
  task automatic fall();
    pair = PAIR_LOW;
    pairB = PAIR_LOW;
    waitClk(6);
  endtask
  // Only the first pair crosses; the module must treat this as noise
  task automatic glitch(input logic [3:0] code, input logic [BA_W-1:0] b,
                        input logic [ADDR_W-1:0] a);
    pins = {code, b, a};
    pair = PAIR_HIGH;
    waitClk(6);
    pins = {CMD_NOP, b, a};
    pair = PAIR_LOW;
    waitClk(6);
  endtask
  // Write access: strobes parked low first, then one edge per word
  task automatic write(input logic [BA_W-1:0] b, input logic [1:0] col,
                       input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi,
                       input logic [LANES-1:0] msk);
    strobes = 8'h00;
    strobeOe = LANES_ALL;
    masks = msk;
    data = lo;
    dataDrv = 1'b1;
    rise(CMD_WR, b, {11'h000, col});
    pair = PAIR_LOW;
    pairB = PAIR_LOW;
    strobes = ~strobes;
    waitClk(3);
    data = hi;
    strobes = ~strobes;
    waitClk(3);
    strobeOe = 8'h00;
    dataDrv = 1'b0;
  endtask
endmodule

// >>> test/tb_ddr_module_command_pins.sv
// Self-checking bench for the module command pin logic
module tb_ddr_module_command_pins;
  import ddr_module_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cmd_pins_t pins;
  logic cke;
  logic [1:0] pair, pairB;
  logic [LANES-1:0] masks, mS, mSOe, sOut, sOe, dOe, sWire, sFlt;
  logic [DATA_W-1:0] mD, dOut, dWire, dFlt;
  logic mDrv, srAct, bufRdy;
  pwr_t pState;
  logic [BANKS-1:0] bOpen, expOpen;
  logic [ADDR_W-1:0] mr, emr, v;
  logic [DATA_W-1:0] mem [16][2];
  logic [DATA_W-1:0] lo, hi;
  logic [LANES-1:0] msk;
  logic [BA_W-1:0] b;
  logic [1:0] col;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 66242;
  int idx;
  // Free-running system clock
  always #12.5 clk = ~clk;
  // Released lines show the inverse of their last driven value
  always @(posedge clk) begin
    if (sOe !== 8'h00) sFlt <= ~sOut;
    else if (mSOe !== 8'h00) sFlt <= ~mS;
    if (dOe[0] === 1'b1) dFlt <= ~dOut;
    else if (mDrv === 1'b1) dFlt <= ~mD;
  end
  assign sWire = (sOe & sOut) | (~sOe & mSOe & mS) | (~sOe & ~mSOe & sFlt);
  assign dWire = dOe[0] ? dOut : (mDrv ? mD : dFlt);
  ctrl_model i_ctrl (.clk(clk), .pins(pins), .cke(cke), .pair(pair), .pairB(pairB),
    .masks(masks),
    .strobes(mS), .strobeOe(mSOe), .data(mD), .dataDrv(mDrv));
  ddr_module_command_pins #(.BUF_DEPTH(FIFO_DEPTH)) i_dut (.clk(clk), .rst_n(rst_n),
    .rankSelectN(pins.csN), .rowStrobeN(pins.rasN), .columnStrobeN(pins.casN),
    .writeEnableN(pins.weN), .bankAddress(pins.ba), .address(pins.addr),
    .moduleClockEnable(cke), .moduleClockPairA(pair), .moduleClockPairB(pairB),
    .byteLaneWriteMasks(masks), .byteLaneStrobesIn(sWire), .byteLaneStrobesOut(sOut),
    .byteLaneStrobesOe(sOe), .dataIn(dWire), .dataOut(dOut), .dataOe(dOe),
    .powerState(pState), .selfRefreshActive(srAct), .bankOpen(bOpen), .modeReg(mr),
    .extModeReg(emr), .writeBufReady(bufRdy));
  // Counts, verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One comparison, reported at once on a mismatch
  task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  // Bytes whose mask is low take the new value
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw, input logic [LANES-1:0] m);
    logic [DATA_W-1:0] r;
    r = old;
    for (int l = 0; l < LANES; l++) if (!m[l]) r[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
    return r;
  endfunction
  // Crossing pair carrying a command, then a bank-state compare
  task automatic cmdChk(input logic [3:0] c, input logic [BA_W-1:0] bb,
                        input logic [ADDR_W-1:0] a);
    i_ctrl.rise(c, bb, a);
    i_ctrl.fall();
    chk("bankOpen", expOpen, bOpen);
  endtask
  // Hang guard: the whole sequence needs far fewer cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    expOpen = 4'h0;
    repeat (8) @(posedge clk);
    #2 rst_n = 1'b1;
    i_ctrl.waitClk(2);
    chk("powerState", PWR_RUN, pState);
    chk("bankOpen", expOpen, bOpen);
    chk("modeReg", MODE_RESET, mr);
    chk("writeBufReady", 1'b1, bufRdy);
    $display("test reset done");
    v = 13'($random(seed));
    for (int i = 0; i < 3; i++) begin
      cmdChk(CMD_LMR, 2'(i), v + 13'(i));
    end
    chk("modeReg", v, mr);
    chk("extModeReg", v + 13'h0001, emr);
    $display("test mode registers done");
    cmdChk(4'hB, 2'h2, 13'h0000);
    i_ctrl.glitch(CMD_ACT, 2'h3, 13'h0000);
    chk("bankOpen", expOpen, bOpen);
    for (int i = 0; i < BANKS; i++) begin
      expOpen[i] = 1'b1;
      cmdChk(CMD_ACT, 2'(i), 13'($random(seed)));
    end
    expOpen[1] = 1'b0;
    cmdChk(CMD_PRE, 2'h1, 13'h0000);
    expOpen = 4'h0;
    cmdChk(CMD_PRE, 2'h0, 13'h0400);
    $display("test bank control done");
    for (int k = 0; k < 4; k++) begin
      b = 2'($random(seed));
      col = 2'($random(seed));
      idx = {b, col};
      expOpen[b] = 1'b1;
      cmdChk(CMD_ACT, b, 13'h0000);
      lo = {$random(seed), $random(seed)};
      hi = {$random(seed), $random(seed)};
      i_ctrl.write(b, col, lo, hi, 8'h00);
      mem[idx][0] = lo;
      mem[idx][1] = hi;
      lo = {$random(seed), $random(seed)};
      hi = {$random(seed), $random(seed)};
      msk = (k == 0) ? 8'hFF : 8'($random(seed));
      i_ctrl.write(b, col, lo, hi, msk);
      mem[idx][0] = merge(mem[idx][0], lo, msk);
      mem[idx][1] = merge(mem[idx][1], hi, msk);
      expOpen[b] = 1'b0;
      i_ctrl.rise(CMD_RD, b, {2'h0, 1'b1, 8'h00, col});
      i_ctrl.fall();
      chk("dataOut low", mem[idx][0], dOut);
      chk("dataOe", 8'hFF, dOe);
      chk("strobesOut low", 8'hFF, sOut);
      chk("strobesOe", 8'hFF, sOe);
      i_ctrl.rise(CMD_NOP, b, 13'h0000);
      chk("dataOut high", mem[idx][1], dOut);
      chk("strobesOut high", 8'h00, sOut);
      i_ctrl.fall();
      chk("dataOe off", 8'h00, dOe);
      chk("strobesOe off", 8'h00, sOe);
      chk("bankOpen", expOpen, bOpen);
    end
    $display("test write and read done");
    expOpen = 4'h4;
    cmdChk(CMD_ACT, 2'h2, 13'h0000);
    i_ctrl.setCke(1'b0);
    cmdChk(CMD_NOP, 2'h0, 13'h0000);
    chk("powerState", PWR_ACT_PD, pState);
    cmdChk(CMD_PRE, 2'h0, 13'h0400);
    i_ctrl.setCke(1'b1);
    cmdChk(CMD_NOP, 2'h0, 13'h0000);
    chk("powerState", PWR_RUN, pState);
    expOpen = 4'h0;
    cmdChk(CMD_PRE, 2'h0, 13'h0400);
    i_ctrl.setCke(1'b0);
    cmdChk(CMD_NOP, 2'h0, 13'h0000);
    chk("powerState", PWR_PRE_PD, pState);
    i_ctrl.setCke(1'b1);
    cmdChk(CMD_NOP, 2'h0, 13'h0000);
    chk("powerState", PWR_RUN, pState);
    $display("test power-down done");
    // Reset in mid-run must drop open rows and mode registers
    expOpen = 4'h1;
    cmdChk(CMD_ACT, 2'h0, 13'h0000);
    rst_n = 1'b0;
    i_ctrl.waitClk(2);
    rst_n = 1'b1;
    i_ctrl.waitClk(2);
    expOpen = 4'h0;
    chk("bankOpen", expOpen, bOpen);
    chk("modeReg", MODE_RESET, mr);
    chk("extModeReg", MODE_RESET, emr);
    chk("powerState", PWR_RUN, pState);
    $display("test mid-run reset done");
    i_ctrl.setCke(1'b0);
    cmdChk(CMD_REF, 2'h0, 13'h0000);
    chk("selfRefreshActive", 1'b1, srAct);
    i_ctrl.setCke(1'b1);
    #1;
    chk("selfRefreshActive", 1'b0, srAct);
    i_ctrl.waitClk(6);
    chk("powerState", PWR_RUN, pState);
    $display("test self refresh done");
    complete_run();
  end
endmodule

// >>> verilog/beat_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);

  // Pointers need a power-of-two depth to wrap cleanly
  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
    $error("beat_fifo depth must be a power of two, at least 2");
  end

  logic [PTR_W:0] wrPtr; // Write pointer with wrap bit
  logic [PTR_W:0] rdPtr; // Read pointer with wrap bit
  logic [PTR_W:0] next_wrPtr;
  logic [PTR_W:0] next_rdPtr;
  logic [WIDTH-1:0] store [DEPTH]; // Entries
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign next_wrPtr = push ? wrPtr + 1'h1 : wrPtr;
  assign next_rdPtr = pop ? rdPtr + 1'h1 : rdPtr;
  assign outData = store[rdPtr[PTR_W-1:0]];

  // Pointers and registered full and empty flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      inReady <= 1'h1;
      outValid <= 1'h0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      outValid <= next_wrPtr != next_rdPtr;
      inReady <= !(next_wrPtr[PTR_W] != next_rdPtr[PTR_W] &&
                   next_wrPtr[PTR_W-1:0] == next_rdPtr[PTR_W-1:0]);
    end
  end

  // Storage needs no reset; empty flag guards stale entries
  always_ff @(posedge clk) begin
    if (push) begin
      store[wrPtr[PTR_W-1:0]] <= inData;
    end
  end
endmodule

// >>> verilog/ddr_module_command_pins.sv
// Command, clock-enable, address, strobe and mask logic of the memory module
module ddr_module_command_pins
  import ddr_module_pkg::*;
#(
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rankSelectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeEnableN,
  input wire logic [BA_W-1:0] bankAddress,
  input wire logic [ADDR_W-1:0] address,
  input wire logic moduleClockEnable,
  input wire logic [1:0] moduleClockPairA,
  input wire logic [1:0] moduleClockPairB,
  input wire logic [LANES-1:0] byteLaneWriteMasks,
  input wire logic [LANES-1:0] byteLaneStrobesIn,
  output logic [LANES-1:0] byteLaneStrobesOut,
  output logic [LANES-1:0] byteLaneStrobesOe,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic [LANES-1:0] dataOe,
  output pwr_t powerState,
  output logic selfRefreshActive,
  output logic [BANKS-1:0] bankOpen,
  output logic [ADDR_W-1:0] modeReg,
  output logic [ADDR_W-1:0] extModeReg,
  output logic writeBufReady
);
  // Buffer must hold at least one full access
  if (BUF_DEPTH < 2) begin : g_bad_buf
    $error("write buffer needs at least two entries");
  end

  pin_sample_t rawPins; // Pins as they arrive
  pin_sample_t syncMeta; // First synchroniser stage
  pin_sample_t syncPins; // Safe copy for logic
  pin_sample_t prevPins; // One cycle older, for edges

  assign rawPins = {rankSelectN, rowStrobeN, columnStrobeN, writeEnableN,
                    bankAddress, address, moduleClockPairA, moduleClockPairB,
                    moduleClockEnable, byteLaneStrobesIn, byteLaneWriteMasks,
                    dataIn};

  // Two-stage synchroniser; all pins share one delay so they stay aligned
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncMeta <= '0;
      syncPins <= '0;
      prevPins <= '0;
    end else begin
      syncMeta <= rawPins;
      syncPins <= syncMeta;
      prevPins <= syncPins;
    end
  end

  logic riseX; // True rises, complement falls
  logic fallX; // True falls, complement rises

  // Both pairs must agree; a lone pair is treated as a glitch
  assign riseX = syncPins.pairA == PAIR_HIGH && syncPins.pairB == PAIR_HIGH &&
                 prevPins.pairA != PAIR_HIGH;
  assign fallX = syncPins.pairA == PAIR_LOW && syncPins.pairB == PAIR_LOW &&
                 prevPins.pairA != PAIR_LOW;

  logic [3:0] cmdCode; // Select plus three strobes
  logic [BA_W-1:0] cmdBank; // Target bank
  logic [ADDR_W-1:0] cmdAddr; // Address lines
  logic [IDX_W-1:0] cmdIdx; // Bank and column for storage
  logic decodeOn; // Decoder live at this crossing
  logic cmdTake; // Command taken
  logic bankHit; // Target bank has a row open
  rd_t rdState; // Read sequence
  logic wrActive; // Write access in progress
  logic bufHasData; // Write beats still queued

  assign cmdCode = {syncPins.cmd.csN, syncPins.cmd.rasN, syncPins.cmd.casN,
                    syncPins.cmd.weN};
  assign cmdBank = syncPins.cmd.ba;
  assign cmdAddr = syncPins.cmd.addr;
  assign cmdIdx = {cmdBank, cmdAddr[COL_BITS-1:0]};
  assign bankHit = bankOpen[cmdBank];
  // Buffers are off outside run, so nothing is decoded there
  assign decodeOn = riseX && powerState == PWR_RUN && !selfRefreshActive &&
                    syncPins.cke;
  assign cmdTake = decodeOn && !syncPins.cmd.csN;

  logic takeAct; // Activate
  logic takePre; // Precharge
  logic takeRd; // Read accepted
  logic takeWr; // Write accepted
  logic takeLmr; // Mode register load
  logic srEnter; // Self refresh entry

  // Command decoder; reads and writes are dropped unless the path is free
  always_comb begin
    takeAct = 1'h0;
    takePre = 1'h0;
    takeRd = 1'h0;
    takeWr = 1'h0;
    takeLmr = 1'h0;
    if (cmdTake) begin
      case (cmdCode)
        CMD_ACT: takeAct = 1'h1;
        CMD_PRE: takePre = 1'h1;
        CMD_RD: takeRd = bankHit && rdState == RD_IDLE && !wrActive && !bufHasData;
        CMD_WR: takeWr = bankHit && rdState == RD_IDLE && !wrActive && writeBufReady;
        CMD_LMR: takeLmr = 1'h1;
        default: takeAct = 1'h0; // Refresh, stop and no-op leave state alone
      endcase
    end
  end

  // Refresh with enable low and every bank idle enters self refresh
  assign srEnter = riseX && powerState == PWR_RUN && !selfRefreshActive &&
                   !syncPins.cke && !syncPins.cmd.csN && cmdCode == CMD_REF &&
                   bankOpen == '0;

  logic srClearN; // Enable high clears self refresh at once
  logic outKillN; // Enable low drops the drivers at once

  assign srClearN = rst_n && !moduleClockEnable;
  assign outKillN = rst_n && moduleClockEnable;

  // Self refresh: entry on a crossing, exit without waiting for any clock
  always_ff @(posedge clk or negedge srClearN) begin
    if (!srClearN) begin
      selfRefreshActive <= 1'h0;
    end else if (srEnter) begin
      selfRefreshActive <= 1'h1;
    end
  end

  // Power-down entry and exit follow enable sampled at a rising crossing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerState <= PWR_RUN;
    end else begin
      case (powerState)
        PWR_RUN: begin
          if (riseX && !syncPins.cke && !selfRefreshActive && !srEnter) begin
            powerState <= (bankOpen == '0) ? PWR_PRE_PD : PWR_ACT_PD;
          end
        end
        PWR_PRE_PD, PWR_ACT_PD: begin
          if (riseX && syncPins.cke) begin
            powerState <= PWR_RUN;
          end
        end
        default: powerState <= PWR_RUN;
      endcase
    end
  end

  logic [ADDR_W-1:0] openRow [BANKS]; // Row held open per bank

  // Bank rows; auto-precharge closes the bank as the access is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bankOpen <= '0;
      for (int b = 0; b < BANKS; b++) begin
        openRow[b] <= '0;
      end
    end else if (takeAct) begin
      bankOpen[cmdBank] <= 1'h1;
      openRow[cmdBank] <= cmdAddr;
    end else if (takePre) begin
      if (cmdAddr[AP_BIT]) begin
        bankOpen <= '0;
      end else begin
        bankOpen[cmdBank] <= 1'h0;
      end
    end else if ((takeRd || takeWr) && cmdAddr[AP_BIT]) begin
      bankOpen[cmdBank] <= 1'h0;
    end
  end

  // Mode registers; other bank codes are reserved and ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg <= MODE_RESET;
      extModeReg <= MODE_RESET;
    end else if (takeLmr && cmdBank == BA_BASE_MR) begin
      modeReg <= cmdAddr;
    end else if (takeLmr && cmdBank == BA_EXT_MR) begin
      extModeReg <= cmdAddr;
    end
  end

  logic [LANES-1:0] strobeEdge; // Controller moved a lane strobe
  logic [LANES-1:0] laneWrite; // Lane byte to be stored
  logic [DATA_W-1:0] readLow; // First half of an access
  logic [DATA_W-1:0] readHigh; // Second half of an access
  logic [IDX_W-1:0] rdIdx; // Access being read
  logic [IDX_W-1:0] wrIdx; // Access being written
  logic wrHalf; // Which half the next write beat fills
  wbeat_t pushWord; // Beat into the buffer
  wbeat_t popWord; // Beat out of the buffer
  logic pushValid;
  logic popReady;
  logic popValid;

  // Write beats; a beat the full buffer refuses is lost, hence writeBufReady
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrActive <= 1'h0;
      wrIdx <= '0;
      wrHalf <= 1'h0;
    end else if (takeWr) begin
      wrActive <= 1'h1;
      wrIdx <= cmdIdx;
      wrHalf <= 1'h0;
    end else if (pushValid && writeBufReady) begin
      wrHalf <= 1'h1;
      if (wrHalf) begin
        wrActive <= 1'h0;
      end
    end
  end

  assign pushValid = wrActive && strobeEdge != '0;
  assign pushWord = '{idx: wrIdx, half: wrHalf, en: laneWrite, data: syncPins.data};
  // Storage port is shared, so draining pauses while a read runs
  assign popReady = rdState == RD_IDLE;

  beat_fifo #(
    .WIDTH($bits(wbeat_t)),
    .DEPTH(BUF_DEPTH)
  ) u_write_buf (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(writeBufReady),
    .inData(pushWord),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popWord)
  );

  assign bufHasData = popValid;

  // Per byte lane: strobe edge, mask, and storage
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] laneMem [1 << (IDX_W + 1)]; // Lane bytes per half access

    // Data is stable around the strobe edge, so the edge itself captures
    assign strobeEdge[l] = syncPins.strobes[l] != prevPins.strobes[l];
    assign laneWrite[l] = strobeEdge[l] && !syncPins.masks[l];
    assign readLow[l*LANE_W +: LANE_W] = laneMem[{rdIdx, 1'h0}];
    assign readHigh[l*LANE_W +: LANE_W] = laneMem[{rdIdx, 1'h1}];

    // Masked lanes keep their old byte
    always_ff @(posedge clk) begin
      if (popValid && popReady && popWord.en[l]) begin
        laneMem[{popWord.idx, popWord.half}] <= popWord.data[l*LANE_W +: LANE_W];
      end
    end
  end

  // Read sequence; enable must stay high or the drivers drop mid-burst
  always_ff @(posedge clk or negedge outKillN) begin
    if (!outKillN) begin
      rdState <= RD_IDLE;
      rdIdx <= '0;
      dataOut <= '0;
      dataOe <= '0;
      byteLaneStrobesOut <= '0;
      byteLaneStrobesOe <= '0;
    end else begin
      case (rdState)
        RD_IDLE: begin
          if (takeRd) begin
            rdIdx <= cmdIdx;
            rdState <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (fallX) begin
            dataOut <= readLow;
            dataOe <= LANES_ALL;
            byteLaneStrobesOut <= LANES_ALL;
            byteLaneStrobesOe <= LANES_ALL;
            rdState <= RD_LOW;
          end
        end
        RD_LOW: begin
          if (riseX) begin
            dataOut <= readHigh;
            byteLaneStrobesOut <= '0;
            rdState <= RD_HIGH;
          end
        end
        RD_HIGH: begin
          if (fallX) begin
            dataOe <= '0;
            byteLaneStrobesOe <= '0;
            rdState <= RD_IDLE;
          end
        end
        default: rdState <= RD_IDLE;
      endcase
    end
  end

  // Checks on the behaviour above
  a_select_masks: assert property (
    @(posedge clk) disable iff (!rst_n)
    riseX && syncPins.cmd.csN |=> $stable(bankOpen) && $stable(modeReg))
    else $error("command changed state while select was high");

  a_act_opens: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmdTake && cmdCode == CMD_ACT |=>
      bankOpen[$past(cmdBank)] && openRow[$past(cmdBank)] == $past(cmdAddr))
    else $error("activate did not open the row");

  a_pre_all: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmdTake && cmdCode == CMD_PRE && cmdAddr[AP_BIT] |=> bankOpen == '0)
    else $error("precharge all left a bank open");

  a_pre_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmdTake && cmdCode == CMD_PRE && !cmdAddr[AP_BIT] |=>
      !bankOpen[$past(cmdBank)] && $countones(bankOpen) >= $countones($past(bankOpen)) - 1)
    else $error("single precharge closed the wrong banks");

  a_auto_pre: assert property (
    @(posedge clk) disable iff (!rst_n)
    takeRd && cmdAddr[AP_BIT] |=> !bankOpen[$past(cmdBank)] && rdState == RD_WAIT)
    else $error("auto-precharge read did not close its bank");

  a_base_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    takeLmr && cmdBank == BA_BASE_MR |=> modeReg == $past(cmdAddr) && $stable(extModeReg))
    else $error("base mode register not loaded");

  a_ext_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    takeLmr && cmdBank == BA_EXT_MR |=> extModeReg == $past(cmdAddr) && $stable(modeReg))
    else $error("extended mode register not loaded");

  a_pd_entry: assert property (
    @(posedge clk) disable iff (!rst_n)
    riseX && powerState == PWR_RUN && !syncPins.cke && !selfRefreshActive &&
      !srEnter && bankOpen != '0 |=> powerState == PWR_ACT_PD)
    else $error("open row did not enter active power-down");

  a_drivers_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    !moduleClockEnable |-> dataOe == '0 && byteLaneStrobesOe == '0)
    else $error("drivers on while clock enable low");

  a_sr_exit: assert property (
    @(posedge clk) disable iff (!rst_n)
    moduleClockEnable |-> !selfRefreshActive)
    else $error("self refresh held with clock enable high");

  a_read_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(dataOe[0]) |-> byteLaneStrobesOut == LANES_ALL && byteLaneStrobesOe == LANES_ALL)
    else $error("read strobe not aligned with first data");

  a_strobe_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    byteLaneStrobesOe != '0 |-> rdState == RD_LOW || rdState == RD_HIGH)
    else $error("strobe driven outside a read");
endmodule

// >>> verilog/ddr_module_pkg.sv
// Constants, codes and carrier structs for the module command interface
// What this block does
// - Select and three strobes form the command
// - Sample inputs on rising clock crossing
// - Read data and strobes follow clock crossings
// - Clock enable low stops clock, buffers, drivers
// - Idle banks: precharge power-down or self refresh
// - Enable synchronous for entry, asynchronous for exits (here only self refresh exits at once; power-down waits for a crossing)
// - Power-down and self refresh disable input buffers
// - Select high masks every command
// - Bank address picks the target bank
// - Row address on activate, column otherwise
// - Line ten requests auto-precharge on accesses
// - Line ten picks one bank or all
// - Mode register set loads address op-code
// - Bank address picks base or extended register
// - Strobes travel with data, capture at receiver
// - Read strobes edge-aligned, write strobes centred
// - Mask high blocks write bytes, reads unaffected
// - Strobe toggles only during reads or writes
// - Two data words per clock cycle
package ddr_module_pkg;
  localparam int DATA_W = 64; // Data bus width
  localparam int LANE_W = 8; // Bits per byte lane
  localparam int LANES = DATA_W / LANE_W; // Strobes and masks
  localparam int ADDR_W = 13; // Address lines
  localparam int BA_W = 2; // Bank address lines
  localparam int BANKS = 4; // Internal banks
  localparam int COL_BITS = 2; // Column bits kept in storage
  localparam int AP_BIT = 10; // Auto-precharge and precharge-all line
  localparam int FIFO_DEPTH = 16; // Write beat buffer depth
  localparam int IDX_W = BA_W + COL_BITS; // Access index width
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000; // Mode registers after reset
  localparam logic [BA_W-1:0] BA_BASE_MR = 2'h0; // Selects base mode register
  localparam logic [BA_W-1:0] BA_EXT_MR = 2'h1; // Selects extended mode register
  localparam logic [1:0] PAIR_HIGH = 2'h2; // True high, complement low
  localparam logic [1:0] PAIR_LOW = 2'h1; // True low, complement high
  localparam logic [LANES-1:0] LANES_ALL = 8'hFF; // Every lane
  // Command codes as {select, row strobe, column strobe, write enable}
  typedef enum logic [3:0] {
    CMD_LMR = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
    CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_BST = 4'h6, CMD_NOP = 4'h7
  } cmd_t;
  // Power state of the module
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00, PWR_PRE_PD = 2'b01, PWR_ACT_PD = 2'b10
  } pwr_t;
  // Read sequencing
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00, RD_WAIT = 2'b01, RD_LOW = 2'b10, RD_HIGH = 2'b11
  } rd_t;
  // Command and address pins
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;
  // Every pin input, sampled together
  typedef struct packed {
    cmd_pins_t cmd;
    logic [1:0] pairA;
    logic [1:0] pairB;
    logic cke;
    logic [LANES-1:0] strobes;
    logic [LANES-1:0] masks;
    logic [DATA_W-1:0] data;
  } pin_sample_t;
  // One captured write beat
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic half;
    logic [LANES-1:0] en;
    logic [DATA_W-1:0] data;
  } wbeat_t;
endpackage
